/* File: common/pfs_pkg.sv */
`default_nettype none
package pfs_pkg;
    // System clock
    localparam int SYS_MHZ = 100;
    localparam int SYS_HZ = SYS_MHZ * 1000000;
    // Asynchronous link rates
    localparam int BAUD_SLOW = 230400;
    localparam int BAUD_FAST = 921600;
    localparam logic [8:0] DIV_SLOW = 9'(SYS_HZ / BAUD_SLOW);
    localparam logic [8:0] DIV_FAST = 9'(SYS_HZ / BAUD_FAST);
    // Asynchronous frame rates in Hz
    localparam int FRAME_HZ_SLOW = 3330;
    localparam int FRAME_HZ_FAST = 10000;
    localparam logic [14:0] FRAME_CYC_SLOW = 15'(SYS_HZ / FRAME_HZ_SLOW);
    localparam logic [14:0] FRAME_CYC_FAST = 15'(SYS_HZ / FRAME_HZ_FAST);
    localparam logic [2:0] UART_BYTES = 3'd6;
    localparam logic [3:0] UART_LAST_BIT = 4'd9;
    // Serial clock idle time before the frame state clears
    localparam int IDLE_NS = 10000;
    localparam logic [9:0] IDLE_CYC = 10'((IDLE_NS * SYS_MHZ + 999) / 1000);
    // Measurement timeout window in us; the middle is used
    localparam int MTO_US_MIN = 135;
    localparam int MTO_US_MAX = 145;
    localparam logic [13:0] MTO_CYC = 14'(((MTO_US_MIN + MTO_US_MAX) / 2) * SYS_MHZ);
    // Clocked frame layout
    localparam logic [5:0] SPI_LAST_BIT = 6'd47;
    localparam int SPI_ZF_BIT = 32;
    localparam int SPI_SD_BIT = 7;
    localparam int POS_W = 22;
    // Checksums, both MSB first, zero start, no final XOR
    localparam logic [15:0] CRC16_POLY = 16'h8005;
    localparam logic [6:0] CRC7_POLY = 7'h5b;

    // CRC-16 over a 48-bit word
    function automatic logic [15:0] crc16(input logic [47:0] d);
        logic [15:0] c;
        logic fb;
        c = 16'h0000;
        for (int i = 47; i >= 0; i--) begin
            fb = d[i] ^ c[15];
            c = {c[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
        end
        return c;
    endfunction

    // CRC-7 over a 32-bit word
    function automatic logic [6:0] crc7(input logic [31:0] d);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int i = 31; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

/* File: rtl/pfs_uart_tx.sv */
`default_nettype none
module pfs_uart_tx (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Byte request
    input wire logic fast,
    input wire logic start,
    input wire logic [7:0] data,
    output logic busy,
    // Line
    output logic txd
);
    logic busy_reg, busy_next; // Character in flight
    logic [9:0] sh_reg, sh_next; // Stop, data, start; LSB leaves first
    logic [3:0] bit_reg, bit_next; // Bit now on the line
    logic [8:0] div_reg, div_next; // Baud divider
    logic txd_reg, txd_next; // Line level, idle high
    logic [8:0] div_top; // Divider reload

    // Next state of the character shifter
    always_comb begin
        div_top = fast ? pfs_pkg::DIV_FAST - 9'd1 : pfs_pkg::DIV_SLOW - 9'd1; // R2
        busy_next = busy_reg;
        sh_next = sh_reg;
        bit_next = bit_reg;
        div_next = div_reg;
        if (busy_reg) begin
            if (div_reg == 9'd0) begin
                div_next = div_top;
                if (bit_reg == pfs_pkg::UART_LAST_BIT) begin
                    busy_next = 1'b0;
                end else begin
                    bit_next = bit_reg + 4'd1;
                    sh_next = {1'b1, sh_reg[9:1]};
                end
            end else begin
                div_next = div_reg - 9'd1;
            end
        end else if (start) begin
            // One start bit, eight data bits LSB first, one stop bit
            sh_next = {1'b1, data, 1'b0}; // R1 R25
            busy_next = 1'b1;
            bit_next = 4'd0;
            div_next = div_top;
        end
        txd_next = busy_next ? sh_next[0] : 1'b1;
    end

    // Register the shifter
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
            sh_reg <= 10'h3ff;
            bit_reg <= 4'd0;
            div_reg <= 9'd0;
            txd_reg <= 1'b1;
        end else begin
            busy_reg <= busy_next;
            sh_reg <= sh_next;
            bit_reg <= bit_next;
            div_reg <= div_next;
            txd_reg <= txd_next;
        end
    end

    assign busy = busy_reg;
    assign txd = txd_reg;
endmodule
`default_nettype wire

/* File: rtl/pfs_spi_link.sv */
`default_nettype none
module pfs_spi_link (
    // Link clock and frame clear
    input wire logic link_sclk,
    input wire logic link_clr,
    // Frame word, held steady by the system side
    input wire logic [47:0] frame_word,
    // Data out
    output logic link_miso
);
    logic [5:0] pos_reg, pos_next; // Frame bit now on the line
    logic miso_reg, miso_next; // Output bit

    // Step to the next bit on each rising edge, MSB first, wrapping
    always_comb begin
        pos_next = (pos_reg == 6'd0) ? pfs_pkg::SPI_LAST_BIT : pos_reg - 6'd1; // R24
        miso_next = frame_word[pos_next]; // R11
    end

    // The clear is asynchronous because this clock stops while idle;
    // it is a short pulse while the clock idles high, so it never meets an edge.
    always_ff @(posedge link_sclk or posedge link_clr) begin
        if (link_clr) begin
            pos_reg <= 6'd47;
            miso_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            miso_reg <= miso_next;
        end
    end

    assign link_miso = miso_reg;

    // The padding bits always leave as zero
    a_link_pad_zero: assert property (@(posedge link_sclk) disable iff (link_clr) // R13
        (pos_reg > 6'd32) |-> !link_miso)
        else $error("padding bit driven high");
endmodule
`default_nettype wire

/* File: rtl/pfs_frame_serializer.sv */
// Function
// R1 - UART characters N-8-1, frames sent unprompted
// R2 - Baud 230400 slow, 921600 fast
// R3 - Frame rate 3.33 kHz slow, 10 kHz fast
// R4 - Asynchronous frame is exactly six bytes
// R5 - Byte layout: marker, flags, angle, CRC
// R6 - Factory zero flag high at default
// R7 - Unused upper angle bits forced zero
// R8 - Angle meaningless while valid flag low
// R9 - CRC-16 0x8005 over 48 bits
// R10 - Clocked frame is six bytes, 48 bits
// R11 - Clock idles high, data changes rising
// R12 - Host clock between 100 kHz, 5 MHz
// R13 - Clocked frame bits 47..33 zero
// R14 - Factory zero bit 32, valid bit 31
// R15 - Bit 30 set when host triggered
// R16 - Angle word in bits 29..8
// R17 - Bit 7 set for repeated sample
// R18 - CRC-7 0x5B in bits 6..0
// R19 - CRC-7 over bits 32..7 zero-extended
// R20 - Host frame triggers measurement unless busy
// R21 - Timeout about 140 us self-triggers
// R22 - Report last completed measurement only
// R23 - Clock idle 10 us clears frame
// R24 - Clocked bits leave MSB first
// R25 - UART bytes in order, LSB first
`default_nettype none
module pfs_frame_serializer #(
    parameter logic [14:0] FRAME_CYC_SLOW = pfs_pkg::FRAME_CYC_SLOW,
    parameter logic [14:0] FRAME_CYC_FAST = pfs_pkg::FRAME_CYC_FAST,
    parameter logic [13:0] MTO_CYC = pfs_pkg::MTO_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Product option straps
    input wire logic clocked_frame_option,
    input wire logic uart_option_fast,
    input wire logic [4:0] resolution_bits,
    // Measurement engine
    output logic meas_start,
    input wire logic meas_done,
    input wire logic [21:0] angle_word,
    input wire logic position_valid_flag,
    input wire logic zero_at_factory_flag,
    // Asynchronous link
    output logic uart_txd,
    // Clocked link
    input wire logic link_sclk,
    output logic link_miso
);
    // Mask of the bits a device of this resolution can set
    function automatic logic [21:0] res_mask(input logic [4:0] r);
        return (r >= 5'd22) ? 22'h3fffff : ((22'h1 << r) - 22'h1);
    endfunction

    // Clocked frame word with its CRC-7
    function automatic logic [47:0] spi_word(input logic zf, input logic pv,
            input logic ps, input logic [21:0] a, input logic sd);
        logic [25:0] f;
        f = {zf, pv, ps, a, sd}; // R14 R15 R16 R17
        return {15'h0000, f, pfs_pkg::crc7({6'h00, f})}; // R13 R18 R19
    endfunction

    // Asynchronous frame of six bytes with its CRC-16
    function automatic logic [47:0] uart_frame(input logic pv, input logic zf,
            input logic [21:0] a);
        logic [47:0] z;
        logic [15:0] c;
        z = {1'b1, pv, zf, 2'b00, a[21:19], 1'b0, a[18:12], 1'b0, a[11:5], // R5
            1'b0, a[4:0], 18'h00000};
        c = pfs_pkg::crc16(z); // R9
        return {z[47:18], c[15:14], 1'b0, c[13:7], 1'b0, c[6:0]}; // R4 R5
    endfunction

    logic spi_mode; // Clocked option selected
    assign spi_mode = clocked_frame_option;

    // Serial clock synchroniser and frame tracking
    logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg; // Two stages plus edge history
    logic [9:0] idle_cnt_reg, idle_cnt_next; // Clock-high time
    logic link_clr_reg, link_clr_next; // Holds the link logic in its start state
    logic [5:0] bit_cnt_reg, bit_cnt_next; // Falling edges seen in this frame
    logic sclk_fall; // Host capture edge
    logic frame_start; // First capture edge of a frame
    logic idle_hit; // Clock idle long enough

    // Follow the host frame from the oversampled clock
    always_comb begin
        sclk_fall = sclk_s3_reg && !sclk_s2_reg;
        frame_start = spi_mode && sclk_fall && (bit_cnt_reg == 6'd0);
        idle_hit = sclk_s2_reg && (idle_cnt_reg == pfs_pkg::IDLE_CYC - 10'd1);
        // Count stops one past the hit, so the hit is a single pulse
        idle_cnt_next = !sclk_s2_reg ? 10'd0 : ((idle_cnt_reg == pfs_pkg::IDLE_CYC) ? idle_cnt_reg
            : idle_cnt_reg + 10'd1);
        // Clear lifts while the clock still idles; waiting for the first fall
        // through the synchroniser would race a fast host's first rising edge
        link_clr_next = !spi_mode || idle_hit; // R23
        bit_cnt_next = bit_cnt_reg;
        if (idle_hit || !spi_mode) begin
            bit_cnt_next = 6'd0; // R23
        end else if (sclk_fall) begin
            // Back-to-back frames wrap after the last bit
            bit_cnt_next = (bit_cnt_reg == pfs_pkg::SPI_LAST_BIT) ? 6'd0 : bit_cnt_reg + 6'd1; // R10
        end
    end

    // Register the synchroniser and frame tracking
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sclk_s1_reg <= 1'b1;
            sclk_s2_reg <= 1'b1;
            sclk_s3_reg <= 1'b1;
            idle_cnt_reg <= 10'd0;
            link_clr_reg <= 1'b1;
            bit_cnt_reg <= 6'd0;
        end else begin
            sclk_s1_reg <= link_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            idle_cnt_reg <= idle_cnt_next;
            link_clr_reg <= link_clr_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Measurement triggering and result store
    logic busy_reg, busy_next; // Measurement in flight
    logic meas_start_reg, meas_start_next; // One-cycle trigger
    logic [13:0] mto_cnt_reg, mto_cnt_next; // Time since last trigger
    logic trig_sync_reg, trig_sync_next; // In-flight measurement was host started
    logic [21:0] res_angle_reg, res_angle_next; // Last completed angle
    logic res_pv_reg, res_pv_next;
    logic res_zf_reg, res_zf_next;
    logic res_ps_reg, res_ps_next;
    logic sent_reg, sent_next; // Last result already went out on the clocked link
    logic [47:0] frame_word_reg, frame_word_next; // Word the link shifts out
    logic tmo_hit; // Timeout elapsed
    logic host_trig; // Host frame began
    logic ftick; // Asynchronous frame period elapsed

    // Decide triggers and capture results
    always_comb begin
        tmo_hit = (mto_cnt_reg == MTO_CYC - 14'd1);
        host_trig = frame_start;
        // A host frame while busy does not retrigger
        meas_start_next = !busy_reg && (host_trig || tmo_hit || (!spi_mode && ftick)); // R20 R21
        trig_sync_next = meas_start_next ? host_trig : trig_sync_reg; // R15
        busy_next = meas_start_next || (busy_reg && !meas_done);
        mto_cnt_next = meas_start_next ? 14'd0 : (tmo_hit ? mto_cnt_reg : mto_cnt_reg + 14'd1);
        res_angle_next = res_angle_reg;
        res_pv_next = res_pv_reg;
        res_zf_next = res_zf_reg;
        res_ps_next = res_ps_reg;
        sent_next = sent_reg;
        frame_word_next = frame_word_reg;
        if (frame_start) begin
            // Only the stored, finished result goes out
            frame_word_next = spi_word(res_zf_reg, res_pv_reg, res_ps_reg, // R22
                res_angle_reg, sent_reg); // R17
            sent_next = 1'b1;
        end
        if (meas_done) begin
            // A new sample beats a same-cycle frame start, which took the old one
            res_angle_next = angle_word & res_mask(resolution_bits); // R7
            res_pv_next = position_valid_flag; // R8
            res_zf_next = zero_at_factory_flag; // R6
            res_ps_next = trig_sync_reg; // R15
            sent_next = 1'b0; // R17
        end
    end

    // Register the trigger and result state
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
            meas_start_reg <= 1'b0;
            mto_cnt_reg <= 14'd0;
            trig_sync_reg <= 1'b0;
            res_angle_reg <= 22'h000000;
            res_pv_reg <= 1'b0;
            res_zf_reg <= 1'b0;
            res_ps_reg <= 1'b0;
            sent_reg <= 1'b0;
            frame_word_reg <= 48'h000000000000;
        end else begin
            busy_reg <= busy_next;
            meas_start_reg <= meas_start_next;
            mto_cnt_reg <= mto_cnt_next;
            trig_sync_reg <= trig_sync_next;
            res_angle_reg <= res_angle_next;
            res_pv_reg <= res_pv_next;
            res_zf_reg <= res_zf_next;
            res_ps_reg <= res_ps_next;
            sent_reg <= sent_next;
            frame_word_reg <= frame_word_next;
        end
    end

    // Asynchronous frame sequencing
    logic [14:0] ftick_cnt_reg, ftick_cnt_next; // Frame period timer
    logic [47:0] ufrm_reg, ufrm_next; // Bytes still to send, next in top byte
    logic [2:0] uidx_reg, uidx_next; // Bytes handed to the transmitter
    logic ustart_reg, ustart_next; // Byte request
    logic uload; // A new frame is taken
    logic tx_busy; // Transmitter occupied
    logic [14:0] fper; // Selected period

    // Pace frames and feed bytes one at a time
    always_comb begin
        fper = uart_option_fast ? FRAME_CYC_FAST : FRAME_CYC_SLOW; // R3
        ftick = (ftick_cnt_reg == fper - 15'd1);
        ftick_cnt_next = (ftick || spi_mode) ? 15'd0 : ftick_cnt_reg + 15'd1;
        // A frame still in progress lets a tick pass rather than tear
        uload = !spi_mode && ftick && (uidx_reg == pfs_pkg::UART_BYTES); // R1
        ufrm_next = ufrm_reg;
        uidx_next = uidx_reg;
        ustart_next = 1'b0;
        // Shift first, so a load in the same cycle is not torn
        if (ustart_reg) begin
            ufrm_next = {ufrm_reg[39:0], 8'h00};
        end
        if (uload) begin
            ufrm_next = uart_frame(res_pv_reg, res_zf_reg, res_angle_reg); // R22
            uidx_next = 3'd0;
        end else if (!ustart_reg && !tx_busy && uidx_reg != pfs_pkg::UART_BYTES) begin
            // Flag byte first, last CRC byte last
            ustart_next = 1'b1; // R25
            uidx_next = uidx_reg + 3'd1; // R4
        end
    end

    // Register the frame sequencer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ftick_cnt_reg <= 15'd0;
            ufrm_reg <= 48'h000000000000;
            uidx_reg <= pfs_pkg::UART_BYTES;
            ustart_reg <= 1'b0;
        end else begin
            ftick_cnt_reg <= ftick_cnt_next;
            ufrm_reg <= ufrm_next;
            uidx_reg <= uidx_next;
            ustart_reg <= ustart_next;
        end
    end

    // Character transmitter
    pfs_uart_tx u_tx (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .fast(uart_option_fast),
        .start(ustart_reg),
        .data(ufrm_reg[47:40]),
        .busy(tx_busy),
        .txd(uart_txd)
    );

    // Clocked link shifter in the serial clock domain
    pfs_spi_link u_link (
        .link_sclk(link_sclk),
        .link_clr(link_clr_reg),
        .frame_word(frame_word_reg),
        .link_miso(link_miso)
    );

    assign meas_start = meas_start_reg;

    // Checks
    a_idle_clear: assert property (@(posedge sys_clk) disable iff (!nrst) // R23
        (spi_mode && idle_hit) |=> (link_clr_reg && bit_cnt_reg == 6'd0))
        else $error("idle clock did not clear the frame");
    a_host_trigger: assert property (@(posedge sys_clk) disable iff (!nrst) // R20
        (frame_start && !busy_reg) |=> (meas_start && trig_sync_reg && busy_reg))
        else $error("host frame did not trigger");
    a_no_retrigger: assert property (@(posedge sys_clk) disable iff (!nrst) // R20
        (busy_reg && !meas_done) |=> !meas_start)
        else $error("trigger while busy");
    a_tmo_trigger: assert property (@(posedge sys_clk) disable iff (!nrst) // R21
        (spi_mode && tmo_hit && !busy_reg && !frame_start) |=> (meas_start && !trig_sync_reg))
        else $error("timeout did not trigger");
    a_pad_zero: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
        frame_word_reg[47:33] == 15'h0000)
        else $error("padding bits set");
    a_crc7_ok: assert property (@(posedge sys_clk) disable iff (!nrst) // R18
        frame_start |=> frame_word_reg[6:0] == pfs_pkg::crc7({6'h00, frame_word_reg[32:7]}))
        else $error("bad clocked CRC");
    a_stale_flag: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
        (frame_start && !meas_done) |=> (frame_word_reg[pfs_pkg::SPI_SD_BIT] == $past(sent_reg)
            && sent_reg && frame_word_reg[pfs_pkg::SPI_ZF_BIT] == $past(res_zf_reg)))
        else $error("repeat flag wrong");
    a_uart_frame: assert property (@(posedge sys_clk) disable iff (!nrst) // R9
        uload |=> (ufrm_reg[47] && !ufrm_reg[39] && !ufrm_reg[31] && !ufrm_reg[23]
            && !ufrm_reg[15] && !ufrm_reg[7] && {ufrm_reg[17:16], ufrm_reg[14:8], ufrm_reg[6:0]}
            == pfs_pkg::crc16({ufrm_reg[47:18], 18'h00000})))
        else $error("bad asynchronous frame");
    a_res_mask: assert property (@(posedge sys_clk) disable iff (!nrst) // R7
        meas_done |=> (res_angle_reg & ~res_mask($past(resolution_bits))) == 22'h000000)
        else $error("unused angle bits set");
    c_host_frame: cover property (@(posedge sys_clk) disable iff (!nrst)
        frame_start ##1 meas_start);
    c_timeout: cover property (@(posedge sys_clk) disable iff (!nrst)
        spi_mode && tmo_hit && !busy_reg);
    c_stale: cover property (@(posedge sys_clk) disable iff (!nrst)
        frame_start && sent_reg);
    c_uart_frame: cover property (@(posedge sys_clk) disable iff (!nrst)
        ustart_reg && uidx_reg == pfs_pkg::UART_BYTES);
endmodule
`default_nettype wire

/* File: testbench/pfs_host_model.sv */
`default_nettype none
module pfs_host_model (
    // System clock, used for bit timing
    input wire logic sys_clk,
    // Asynchronous link
    input wire logic fast,
    input wire logic txd,
    output logic [7:0] rx_byte,
    output logic rx_stop,
    output logic rx_stb,
    // Clocked link, host is master
    input wire logic miso,
    output logic sclk,
    output logic [47:0] spi_word,
    output logic spi_stb
);
    timeunit 1ns;
    timeprecision 1ps;

    // Serial clock stands high between frames
    initial begin
        sclk = 1'b1;
        rx_stb = 1'b0;
        spi_stb = 1'b0;
        rx_byte = 8'h00;
        rx_stop = 1'b0;
        spi_word = 48'h0;
    end

    // Receiver samples mid-bit at the rate the strap selects
    initial begin : rx_p
        int div;
        forever begin
            @(negedge txd);
            div = fast ? int'(pfs_pkg::DIV_FAST) : int'(pfs_pkg::DIV_SLOW);
            repeat (div / 2) @(posedge sys_clk);
            // Eight data bits, first one is bit 0
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge sys_clk);
                rx_byte[i] = txd;
            end
            repeat (div) @(posedge sys_clk);
            rx_stop = txd;
            rx_stb = 1'b1;
            #1 rx_stb = 1'b0;
        end
    end

    // One frame of n clocks; sampled on falling edge, MSB arrives first
    // Period is fixed by the bench, faster than a real host, to keep runs short
    task automatic spi_frame(input int n);
        #3;
        for (int i = 0; i < n; i++) begin
            #24 sclk = 1'b0;
            spi_word = {spi_word[46:0], miso};
            #24 sclk = 1'b1;
        end
        // Only whole frames are reported
        if (n == 48) begin
            spi_stb = 1'b1;
            #1 spi_stb = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_pfs_frame_serializer.sv */
`default_nettype none
module tb_pfs_frame_serializer;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset, straps
    logic sys_clk;
    logic nrst;
    logic spi_mode;
    logic fast;
    logic [4:0] res;
    // Engine stand-in
    logic meas_start;
    logic meas_done;
    logic [21:0] ang;
    logic pv;
    logic zf;
    logic vary;
    int dly;
    int cnt;
    // Links
    logic txd;
    logic sclk;
    logic miso;
    logic [7:0] rx_byte;
    logic rx_stop;
    logic rx_stb;
    logic [47:0] spi_word;
    logic spi_stb;
    // Score keeping
    int fails;
    int compares;
    int nrx;
    logic [47:0] exp_q[$];

    // Shortened frame periods and timeout keep the run brief
    pfs_frame_serializer #(.FRAME_CYC_SLOW(15'd27000), .FRAME_CYC_FAST(15'd7000),
        .MTO_CYC(14'd600)) pfs_frame_serializer_inst (.sys_clk(sys_clk), .nrst(nrst),
        .clocked_frame_option(spi_mode), .uart_option_fast(fast), .resolution_bits(res),
        .meas_start(meas_start), .meas_done(meas_done), .angle_word(ang),
        .position_valid_flag(pv), .zero_at_factory_flag(zf), .uart_txd(txd),
        .link_sclk(sclk), .link_miso(miso));

    pfs_host_model pfs_host_model_inst (.sys_clk(sys_clk), .fast(fast), .txd(txd),
        .rx_byte(rx_byte), .rx_stop(rx_stop), .rx_stb(rx_stb), .miso(miso), .sclk(sclk),
        .spi_word(spi_word), .spi_stb(spi_stb));

    // 100 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Engine answers after dly cycles; new values only while vary is set
    always @(posedge sys_clk) begin
        meas_done <= (cnt == 1);
        if (cnt == 1) begin
            if (vary) begin
                ang <= 22'($urandom);
                pv <= 1'($urandom);
                zf <= 1'($urandom);
            end
        end
        if (meas_start) begin
            cnt <= dly;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    // Bitwise MSB-first checksum, zero start, no final XOR
    function automatic logic [15:0] crc_f(input logic [47:0] d, input int n,
        input logic [15:0] p, input int w);
        logic [15:0] c;
        logic fb;
        c = 16'h0000;
        for (int i = n - 1; i >= 0; i--) begin
            fb = d[i] ^ c[w - 1];
            c = ((c << 1) ^ (fb ? p : 16'h0000)) & 16'((32'h1 << w) - 1);
        end
        return c;
    endfunction

    // Angle with bits at and above the resolution cleared
    function automatic logic [21:0] angle_m();
        return (res >= 5'd22) ? ang : ang & ((22'h1 << res) - 22'h1);
    endfunction

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Six expected bytes of one asynchronous frame, in wire order
    task automatic push_uart();
        logic [21:0] a;
        logic [47:0] w;
        logic [15:0] c;
        a = angle_m();
        w = {1'b1, pv, zf, 2'b00, a[21:19], 1'b0, a[18:12], 1'b0, a[11:5], 1'b0, a[4:0], 18'h0};
        c = crc_f(w, 48, pfs_pkg::CRC16_POLY, 16);
        w[17:0] = {c[15:14], 1'b0, c[13:7], 1'b0, c[6:0]};
        for (int i = 5; i >= 0; i--) begin
            exp_q.push_back(48'(w[8 * i +: 8]));
        end
    endtask

    // Expected clocked frame from the last completed result
    task automatic push_spi(input logic ps, input logic sd);
        logic [31:0] cw;
        logic [15:0] c;
        cw = {6'h00, zf, pv, ps, angle_m(), sd};
        c = crc_f({16'h0000, cw}, 32, {9'h000, pfs_pkg::CRC7_POLY}, 7);
        exp_q.push_back({15'h0000, cw[25:0], c[6:0]});
    endtask

    // Bounded wait for a count of received characters
    task automatic wait_rx(input int n);
        int lim;
        lim = 0;
        while (nrx < n && lim < 60000) begin
            @(posedge sys_clk);
            lim++;
        end
        if (lim >= 60000) begin
            fails++;
            finish_test();
        end
    endtask

    task automatic do_reset(input logic m, input logic f);
        @(posedge sys_clk);
        nrst <= 1'b0;
        spi_mode <= m;
        fast <= f;
        res <= 5'(16 + $urandom % 7);
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        nrx = 0;
    endtask

    // Watchers take the oldest note whenever a result shows up
    always @(posedge rx_stb) begin
        nrx++;
        chk(48'(rx_stop), 48'h1);
        if (exp_q.size() > 0) chk(48'(rx_byte), exp_q.pop_front());
    end
    always @(posedge spi_stb) begin
        if (exp_q.size() > 0) chk(spi_word, exp_q.pop_front());
    end

    // Hang guard
    initial begin
        repeat (150000) @(posedge sys_clk);
        fails++;
        finish_test();
    end

    initial begin : main_p
        int lim;
        logic fb;
        nrst = 1'b0;
        spi_mode = 1'b0;
        fast = 1'b1;
        res = 5'd22;
        meas_done = 1'b0;
        ang = 22'h0;
        pv = 1'b0;
        zf = 1'b0;
        vary = 1'b0;
        dly = 20;
        cnt = 0;
        fails = 0;
        compares = 0;
        nrx = 0;
        void'($urandom(32'h2270));
        fb = 1'($urandom);
        // Both baud options in random order; first frame after reset is skipped
        for (int f = 1; f >= 0; f--) begin
            ang <= 22'($urandom);
            pv <= 1'($urandom);
            zf <= 1'($urandom);
            do_reset(1'b0, f[0] ^ fb);
            wait_rx(6);
            push_uart();
            wait_rx(12);
        end
        // Clocked link: idle long enough to arm, timeout-made sample first
        do_reset(1'b1, fb);
        repeat (1100) @(posedge sys_clk);
        push_spi(1'b0, 1'b0);
        pfs_host_model_inst.spi_frame(48);
        // Host frame made the next sample; slow engine then leaves it stale
        vary = 1'b1;
        dly = 500;
        push_spi(1'b1, 1'b0);
        pfs_host_model_inst.spi_frame(48);
        push_spi(1'b1, 1'b1);
        pfs_host_model_inst.spi_frame(48);
        lim = 0;
        while (meas_done !== 1'b1 && lim < 1000) begin
            @(posedge sys_clk);
            lim++;
        end
        if (lim >= 1000) fails++;
        @(posedge sys_clk);
        vary = 1'b0;
        dly = 20;
        // Broken frame, long idle, then a clean aligned frame
        pfs_host_model_inst.spi_frame(5);
        repeat (1100) @(posedge sys_clk);
        push_spi(1'b0, 1'b0);
        pfs_host_model_inst.spi_frame(48);
        repeat (20) @(posedge sys_clk);
        finish_test();
    end
endmodule
`default_nettype wire
